// ### rtl/ssr_receiver.sv
// Summary of operation
// - single receive enable ignored in slave
// - keep receiving in sleep or idle
// - full word moves shift reg to buffer
// - receive interrupt wakes from low power
// - cpu branches when global enable set
// - clock polarity bit inverts clock pin
// - data polarity bit inverts data pin
// - nine-bit mode, ninth bit in status
// - continuous enable turns reception on
// - flag set on word, interrupt if enabled
// - errors shown in receive status register
// - low eight bits in data buffer
// - clearing continuous enable clears errors
// - clock source clear selects slave mode
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ssr_receiver (
  input  wire logic        pclk,          // 10 mhz bus clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        shift_clock_pin,   // clock from external master
  input  wire logic        serial_data_pin,   // data from external master
  output logic             irq,           // level interrupt
  output logic             wake           // wake request in low power
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] rx_ctrl_q;     // writable receive control bits
  logic [7:0] tx_ctrl_q;     // transmit_status_control
  logic [7:0] rate_pol_q;    // rate_polarity_control
  logic [7:0] div_high_q;    // rate_divisor_high
  logic [7:0] div_low_q;     // rate_divisor_low
  logic [2:0] irq_stat_q;    // sticky events
  logic [2:0] irq_mask_q;    // event mask
  logic       low_power_q;   // device sleeping or idle
  logic       over_q;        // overrun_error_flag
  logic       frame_q;       // framing_error_flag, never set in sync mode
  ssr_pkg::ssr_word_type buf_q;  // receive_data_buffer plus ninth bit
  logic       buf_full_q;    // buffer holds unread word

  // bus decode
  logic wr_en;   // write takes effect
  logic rd_en;   // read taken
  // a transfer counts only at the edge where the answer is given, so a
  // stretched access phase can neither write twice nor clear twice
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & pready & ~pwrite;

  // mode decode
  logic slave_mode;  // sync slave with port enabled
  logic rx_on;       // reception allowed
  assign slave_mode = rx_ctrl_q[ssr_pkg::RS_PORT_EN] & tx_ctrl_q[ssr_pkg::TS_SYNC]
                      & ~tx_ctrl_q[ssr_pkg::TS_CLK_SRC];
  assign rx_on = slave_mode & rx_ctrl_q[ssr_pkg::RS_CONT];

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // both pins pass two flops before any logic reads them; only the second
  // stage feeds the edge detector, so a metastable first stage never leaks
  logic [1:0] ck_sync_q;  // shift clock sync chain
  logic [1:0] dt_sync_q;  // data sync chain
  logic       ck_prev_q;  // last synced clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_sync_q <= 2'h0;
      dt_sync_q <= 2'h0;
      ck_prev_q <= 1'b0;
    end else begin
      ck_sync_q <= {ck_sync_q[0], shift_clock_pin};
      dt_sync_q <= {dt_sync_q[0], serial_data_pin};
      ck_prev_q <= ck_sync_q[1];
    end
  end

  logic ck_pol;    // clock after polarity
  logic ck_prev;   // previous clock after polarity
  logic dt_pol;    // data after polarity
  logic ck_edge;   // active edge pulse
  assign ck_pol  = ck_sync_q[1] ^ rate_pol_q[ssr_pkg::RP_CLK_POL];
  assign ck_prev = ck_prev_q ^ rate_pol_q[ssr_pkg::RP_CLK_POL];
  assign dt_pol  = dt_sync_q[1] ^ rate_pol_q[ssr_pkg::RP_DATA_POL];
  // polarity is applied to the current and the previous sample alike, so a
  // polarity write while the line idles makes no false edge
  // sample on falling edge of the (polarity-adjusted) clock
  assign ck_edge = ck_prev & ~ck_pol;

  ////////////////////////////////////////////////////////////////////////
  // receive shifter
  ssr_pkg::ssr_rx_state_type state_q;  // receive state
  logic [8:0] shreg_q;   // receive_shift_register
  logic [3:0] cnt_q;     // bits received
  logic [3:0] word_len;  // bits per word
  assign word_len = rx_ctrl_q[ssr_pkg::RS_NINE_SEL] ? 4'(ssr_pkg::WORD_LONG)
                                                    : 4'(ssr_pkg::WORD_SHORT);

  logic word_done;  // full word assembled this cycle
  // gated by rx_on as the shifter is, so a word cut by a disable never lands
  assign word_done = (state_q == ssr_pkg::RX_SHIFT) & rx_on & ck_edge
                     & (cnt_q == word_len - 4'h1);

  // state and shift register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ssr_pkg::RX_OFF;
      shreg_q <= 9'h000;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        ssr_pkg::RX_OFF: begin
          cnt_q <= 4'h0;
          if (rx_on) begin
            state_q <= ssr_pkg::RX_SHIFT;
          end
        end
        ssr_pkg::RX_SHIFT: begin
          if (!rx_on) begin
            state_q <= ssr_pkg::RX_OFF;
          end else if (ck_edge) begin
            shreg_q[cnt_q] <= dt_pol;
            cnt_q          <= cnt_q + 4'h1;
            if (word_done) begin
              state_q <= ssr_pkg::RX_DONE;
            end
          end
        end
        ssr_pkg::RX_DONE: begin
          // one cycle to clear count and shift register; the buffer took the word on entry
          // an active edge in this cycle is lost; the far end must leave at
          // least one bus cycle after the last bit of a word
          cnt_q   <= 4'h0;
          shreg_q <= 9'h000;
          state_q <= rx_on ? ssr_pkg::RX_SHIFT : ssr_pkg::RX_OFF;
        end
      endcase
    end
  end

  // full word including the bit just sampled
  ssr_pkg::ssr_word_type word_in;
  always_comb begin
    word_in = shreg_q;
    if (cnt_q == 4'h8) begin
      word_in.ninth = dt_pol;
    end else begin
      word_in.data[cnt_q[2:0]] = dt_pol;
    end
    if (!rx_ctrl_q[ssr_pkg::RS_NINE_SEL]) begin
      word_in.ninth = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer and errors
  logic rd_data;  // buffer read this cycle
  assign rd_data = rd_en & (paddr == ssr_pkg::ADDR_RX_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q      <= '0;
      buf_full_q <= 1'b0;
      over_q     <= 1'b0;
      frame_q    <= 1'b0;
    end else begin
      if (word_done && buf_full_q && !rd_data) begin
        over_q <= 1'b1;
      end else if (word_done) begin
        buf_q      <= word_in;
        buf_full_q <= 1'b1;
      end else if (rd_data) begin
        buf_full_q <= 1'b0;
      end
      if (!rx_ctrl_q[ssr_pkg::RS_CONT]) begin
        over_q  <= 1'b0;
        frame_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ctrl_q   <= ssr_pkg::RST_RX_STATUS;
      tx_ctrl_q   <= ssr_pkg::RST_TX_STATUS;
      rate_pol_q  <= ssr_pkg::RST_RATE_POL;
      div_high_q  <= ssr_pkg::RST_DIVISOR;
      div_low_q   <= ssr_pkg::RST_DIVISOR;
      irq_mask_q  <= ssr_pkg::RST_IRQ;
    end else if (wr_en) begin
      unique case (paddr)
        ssr_pkg::ADDR_RX_STATUS: rx_ctrl_q  <= {pwdata[7:4], 4'h0};
        ssr_pkg::ADDR_TX_STATUS: tx_ctrl_q  <= pwdata[7:0];
        ssr_pkg::ADDR_RATE_POL:  rate_pol_q <= pwdata[7:0];
        ssr_pkg::ADDR_DIV_HIGH:  div_high_q <= pwdata[7:0];
        ssr_pkg::ADDR_DIV_LOW:   div_low_q  <= pwdata[7:0];
        ssr_pkg::ADDR_IRQ_MASK:  irq_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // low-power state: software enters it, a wake pulse leaves it; kept apart
  // from the other registers so that a write elsewhere cannot mask a wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_q <= 1'b0;
    end else if (wr_en && (paddr == ssr_pkg::ADDR_PWR_CTRL)) begin
      // software request
      low_power_q <= pwdata[0];
    end else if (wake) begin
      // wake leaves low power
      low_power_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events; read of status clears, a new event wins
  logic rd_irq;  // status read
  logic [2:0] ev;  // event pulses
  assign rd_irq = rd_en & (paddr == ssr_pkg::ADDR_IRQ_STATUS);
  // receive flag on word
  // a word that lands while the old one is read out still counts
  assign ev[ssr_pkg::IRQ_RX]   = word_done & ~(buf_full_q & ~rd_data);
  assign ev[ssr_pkg::IRQ_OVER] = word_done & buf_full_q & ~rd_data;
  assign ev[ssr_pkg::IRQ_WAKE] = word_done & low_power_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= ssr_pkg::RST_IRQ;
    end else begin
      irq_stat_q <= (rd_irq ? 3'h0 : irq_stat_q) | ev;
    end
  end

  // interrupt and wake outputs
  // irq follows the next status value, so it drops in the same cycle as a
  // clearing read and rises in the same cycle as the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= |(((rd_irq ? 3'h0 : irq_stat_q) | ev) & irq_mask_q);
      wake <= low_power_q & ev[ssr_pkg::IRQ_RX] & irq_mask_q[ssr_pkg::IRQ_RX];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data; zero wait states
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (paddr)
      ssr_pkg::ADDR_RX_STATUS: rd_mux = {rx_ctrl_q[7:4], 1'b0, frame_q, over_q, buf_q.ninth};
      ssr_pkg::ADDR_RX_DATA:    rd_mux = buf_q.data;
      ssr_pkg::ADDR_TX_STATUS:  rd_mux = tx_ctrl_q;
      ssr_pkg::ADDR_RATE_POL:   rd_mux = rate_pol_q;
      ssr_pkg::ADDR_DIV_HIGH:   rd_mux = div_high_q;
      ssr_pkg::ADDR_DIV_LOW:    rd_mux = div_low_q;
      ssr_pkg::ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_stat_q};
      ssr_pkg::ADDR_IRQ_MASK:   rd_mux = {5'h00, irq_mask_q};
      ssr_pkg::ADDR_PWR_CTRL:   rd_mux = {7'h00, low_power_q};
      default:                  rd_mux = 8'h00;
    endcase
  end

  // anything off the word grid or past the last register is refused
  logic mapped;  // address is a register
  assign mapped = (paddr[1:0] == 2'h0) & (paddr <= ssr_pkg::ADDR_PWR_CTRL);

  // apb answer registered: pready high in the first access cycle
  // prdata is taken in the setup cycle, so a read that clears a flag
  // returns the value that stood before the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  // wake pulse, then the low-power state drops
  sequence wake_then_leave_s;
    wake ##1 !low_power_q;
  endsequence
  // setup cycle of a read of the receive status register
  sequence status_read_s;
    psel && !penable && !pwrite && (paddr == ssr_pkg::ADDR_RX_STATUS);
  endsequence
  // setup cycle of a read of the receive data buffer
  sequence data_read_s;
    psel && !penable && !pwrite && (paddr == ssr_pkg::ADDR_RX_DATA);
  endsequence

  overrun_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_done && buf_full_q && !rd_data |=> over_q && $stable(buf_q))
    else $error("overrun overwrote buffer");
  word_to_buf_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_done && !buf_full_q |=> buf_full_q && buf_q == $past(word_in))
    else $error("word not moved to buffer");
  err_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_ctrl_q[ssr_pkg::RS_CONT] |=> !over_q)
    else $error("error not cleared");
  rx_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_on |=> state_q != ssr_pkg::RX_SHIFT || $past(state_q) == ssr_pkg::RX_OFF)
    else $error("shifting while disabled");
  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[ssr_pkg::IRQ_RX] && irq_mask_q[ssr_pkg::IRQ_RX] |=> irq)
    else $error("irq missing");
  rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[ssr_pkg::IRQ_RX] |=> irq_stat_q[ssr_pkg::IRQ_RX])
    else $error("receive flag not set");
  wake_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_q && ev[ssr_pkg::IRQ_RX] && irq_mask_q[ssr_pkg::IRQ_RX] |=> wake_then_leave_s)
    else $error("no wake");
  // bit count steps by one per edge
  bit_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ssr_pkg::RX_SHIFT && rx_on && ck_edge |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit count wrong");
  ninth_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    word_done && !buf_full_q && !rx_ctrl_q[ssr_pkg::RS_NINE_SEL] |=> !buf_q.ninth)
    else $error("ninth bit set in 8-bit mode");
  status_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read_s |=> prdata[ssr_pkg::RS_OVER] == $past(over_q))
    else $error("status read lost the error flag");
  data_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_read_s |=> prdata == {24'h0, $past(buf_q.data)})
    else $error("data read differs from buffer");

endmodule : ssr_receiver

`default_nettype wire

// ### rtl/ssr_pkg.sv
package ssr_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_RX_STATUS  = 8'h00;  // receive_status_control
  localparam logic [7:0] ADDR_RX_DATA    = 8'h04;  // receive_data_buffer
  localparam logic [7:0] ADDR_TX_STATUS  = 8'h08;  // transmit_status_control
  localparam logic [7:0] ADDR_RATE_POL   = 8'h0c;  // rate_polarity_control
  localparam logic [7:0] ADDR_DIV_HIGH   = 8'h10;  // rate_divisor_high
  localparam logic [7:0] ADDR_DIV_LOW    = 8'h14;  // rate_divisor_low
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;  // sticky event flags
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1c;  // event mask
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h20;  // low-power state

  // receive_status_control field positions
  localparam int RS_PORT_EN  = 7;  // serial_port_enable
  localparam int RS_NINE_SEL = 6;  // nine_bit_receive_select
  localparam int RS_SINGLE   = 5;  // single_receive_enable
  localparam int RS_CONT     = 4;  // continuous_receive_enable
  localparam int RS_FRAME    = 2;  // framing_error_flag
  localparam int RS_OVER     = 1;  // overrun_error_flag
  localparam int RS_NINTH    = 0;  // received_ninth_bit

  // transmit_status_control field positions
  localparam int TS_CLK_SRC = 7;  // clock_source_select
  localparam int TS_SYNC    = 4;  // synchronous mode select

  // rate_polarity_control field positions
  localparam int RP_DATA_POL = 5;  // data_polarity_select
  localparam int RP_CLK_POL  = 4;  // clock_polarity_select

  // interrupt status / mask field positions
  localparam int IRQ_RX   = 0;  // receive_interrupt_flag
  localparam int IRQ_OVER = 1;  // overrun event
  localparam int IRQ_WAKE = 2;  // wake from low-power event

  // reset values
  localparam logic [7:0] RST_RX_STATUS = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h00;
  localparam logic [7:0] RST_RATE_POL  = 8'h00;
  localparam logic [7:0] RST_DIVISOR   = 8'h00;
  localparam logic [2:0] RST_IRQ       = 3'h0;

  // word sizes
  localparam int WORD_SHORT = 8;
  localparam int WORD_LONG  = 9;

  // receive state machine, one-hot
  typedef enum logic [2:0] {
    RX_OFF   = 3'b001,
    RX_SHIFT = 3'b010,
    RX_DONE  = 3'b100
  } ssr_rx_state_type;

  // one received word handed to the buffer
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssr_word_type;

endpackage : ssr_pkg

// ### dv/ssr_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_master_model (
  output var logic shift_clock_pin,  // shift clock toward the receiver
  output var logic serial_data_pin   // serial data toward the receiver
);
  ////////////////////////////////////////////////////////////////////////
  localparam int HALF_NS = 400;  // half of the 800 ns shift clock

  // clock stands still at idle outside frames
  initial begin
    shift_clock_pin = 1'b1;
    serial_data_pin = 1'b0;
  end

  // park the clock at the idle level of the chosen polarity
  task automatic park(input logic cinv);
    #37;
    shift_clock_pin = ~cinv;  // moved off the bus clock edge
  endtask : park

  task automatic send(input logic [8:0] word, input int nbits, input logic cinv,
                      input logic dinv);
    int i;
    #137;
    for (i = 0; i < nbits; i++) begin
      serial_data_pin = word[i] ^ dinv;  // lsb first, held around the edge
      #(HALF_NS);
      shift_clock_pin = cinv;            // active edge
      #(HALF_NS);
      shift_clock_pin = ~cinv;           // back to idle level
    end
    #(HALF_NS);
    serial_data_pin = ~serial_data_pin;  // released line shows no valid level
  endtask : send
endmodule : ssr_master_model

`default_nettype wire

// ### dv/ssr_receiver_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_receiver_tb;
  ////////////////////////////////////////////////////////////////////////
  logic        pclk, presetn, psel, penable, pwrite;  // bus controls
  logic [7:0]  paddr;                                 // bus address
  logic [31:0] pwdata, prdata;                        // bus data
  logic        pready, pslverr, irq, wake;            // design answers
  logic        sck, sdat;                             // link pins
  int          err_total = 0;                         // mismatches
  int          checked   = 0;                         // comparisons
  int          wake_cnt  = 0;                         // wake pulses seen

  ssr_receiver i_ssr_receiver (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock_pin(sck), .serial_data_pin(sdat), .irq(irq), .wake(wake));
  ssr_master_model i_ssr_master_model (.shift_clock_pin(sck), .serial_data_pin(sdat));

  ////////////////////////////////////////////////////////////////////////
  // 100 ns bus clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // count one-cycle wake pulses
  always @(posedge pclk) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, request held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    chk(32'(n), 32'h1);  // answer in the first access cycle
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // read and compare data and error
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd

  // write and compare error
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wr

  // one word from the far-end master, then back on the bus clock
  task automatic frame(input logic [8:0] w, input int n, input logic ci = 1'b0,
                       input logic di = 1'b0);
    i_ssr_master_model.send(w, n, ci, di);
    @(posedge pclk);
  endtask : frame

  // verdict, the single end of the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // watchdog against a hang
  initial begin
    #3000000;
    err_total++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int i;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then refused addresses
    for (i = 0; i < 9; i++) if (i != 1) rd(8'(i * 4), 32'h0);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(8'h24, 32'hff, 1'b1);
    wr(8'h10, 32'h1234_56a5);
    rd(8'h10, 32'ha5);
    wr(8'h14, 32'h5a);
    rd(8'h14, 32'h5a);
    // receive interrupt enabled
    wr(8'h1c, 32'h1);
    // clock source set: no slave reception
    wr(8'h08, 32'h90);
    wr(8'h00, 32'hb0);
    frame(9'h081, 8);
    rd(8'h18, 32'h0);
    // sync slave set up, single enable alone receives nothing
    wr(8'h08, 32'h10);
    wr(8'h00, 32'ha0);
    frame(9'h081, 8);
    rd(8'h18, 32'h0);
    // continuous enable on
    wr(8'h00, 32'h90);
    frame(9'h03c, 8);
    chk({31'h0, irq}, 32'h1);
    rd(8'h00, 32'h90);
    rd(8'h04, 32'h3c);
    rd(8'h18, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // nine-bit word
    wr(8'h00, 32'hd0);
    frame(9'h1a5, 9);
    rd(8'h00, 32'hd1);
    rd(8'h04, 32'ha5);
    rd(8'h18, 32'h1);
    // second word before the first is read
    wr(8'h00, 32'h90);
    wr(8'h1c, 32'h3);
    frame(9'h011, 8);
    frame(9'h022, 8);
    rd(8'h00, 32'h92);
    rd(8'h18, 32'h3);
    rd(8'h04, 32'h11);
    wr(8'h00, 32'h80);
    rd(8'h00, 32'h80);
    // word during low power wakes the chip
    wr(8'h00, 32'h90);
    wr(8'h1c, 32'h5);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h1);
    frame(9'h077, 8);
    chk(32'(wake_cnt), 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(8'h20, 32'h0);
    rd(8'h18, 32'h5);
    rd(8'h04, 32'h77);
    // inverted clock and data, interrupt masked
    wr(8'h00, 32'h80);
    wr(8'h0c, 32'h30);
    rd(8'h0c, 32'h30);
    i_ssr_master_model.park(1'b1);
    @(posedge pclk);
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h90);
    frame(9'h05a, 8, 1'b1, 1'b1);
    rd(8'h04, 32'h5a);
    chk({31'h0, irq}, 32'h0);
    rd(8'h18, 32'h1);
    // second reset in mid-run returns the registers to their reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h18, 32'h0);
    stop_test();
  end
endmodule : ssr_receiver_tb

`default_nettype wire
